/* hw/cfrx_pkg.sv */
package cfrx_pkg;

   // Register byte offsets.
   localparam logic [11:0] RX0_PAYLOAD_LOW_OFS = 12'h1b8;
   localparam logic [11:0] RX0_PAYLOAD_HIGH_OFS = 12'h1bc;
   localparam logic [11:0] RX1_PAYLOAD_LOW_OFS = 12'h1c8;
   localparam logic [11:0] RX1_PAYLOAD_HIGH_OFS = 12'h1cc;
   localparam logic [11:0] FILTER_MASTER_OFS = 12'h200;
   localparam logic [11:0] BANK_MODE_OFS = 12'h204;
   localparam logic [11:0] BANK_SCALE_OFS = 12'h20c;
   localparam logic [11:0] BANK_QUEUE_OFS = 12'h214;
   localparam logic [11:0] BANK_ENABLE_OFS = 12'h21c;
   // Bank filter word window; not decoded here, the modify-permission check uses BANK_WORD_SEL instead.
   localparam logic [11:0] BANK_WORDS_FIRST_OFS = 12'h240;
   localparam logic [11:0] BANK_WORDS_LAST_OFS = 12'h31c;

   // Filter master field layout and reset value.
   localparam int SETUP_MODE_BIT = 0;
   localparam int FIRST_BANK_LSB = 8;
   localparam int FIRST_BANK_W = 6;
   localparam logic [31:0] FILTER_MASTER_RST = 32'h2a1c0e01;
   localparam logic [5:0] FIRST_BANK_MIN = 6'h01;
   localparam logic [5:0] FIRST_BANK_MAX = 6'h1b;

   // Bank count and per-bank register layout.
   localparam int NUM_BANKS = 28;
   localparam logic [27:0] BANK_BITS_RST = 28'h0000000;

   // Byte lane positions inside a payload word.
   localparam int BYTE_W = 8;
   localparam int PAYLOAD_BYTES = 8;

endpackage

/* hw/cfrx_regs.sv */
`timescale 1ns/1ps
`default_nettype none

module cfrx_regs
   import cfrx_pkg::*;
#(
   parameter bit WIDE_VARIANT = 1'b1
) (
   input wire logic CLK,
   input wire logic SYS_RST,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic RX_STORE,
   input wire logic RX_STORE_QUEUE,
   input wire logic [63:0] RX_STORE_PAYLOAD,
   input wire logic [4:0] BANK_WORD_SEL,
   output logic FILTER_SETUP_MODE,
   output logic [5:0] SECOND_PORT_FIRST_BANK,
   output logic [27:0] BANK_LIST_OR_MASK_SEL,
   output logic [27:0] BANK_WIDTH_SEL,
   output logic [27:0] BANK_QUEUE_SEL,
   output logic [27:0] BANK_MATCH_ENABLED,
   output logic BANK_WORDS_WRITABLE
);
   import cfrx_pkg::*;

   typedef enum logic [1:0] {
      CFRX_IDLE = 2'b00,
      CFRX_ACCESS = 2'b01,
      CFRX_DONE = 2'b11
   } cfrx_state_t;

   cfrx_state_t state_r;
   cfrx_state_t state_nxt;

   logic filter_setup_mode_r;
   logic [5:0] second_port_first_bank_r;
   logic [27:0] bank_list_or_mask_sel_r;
   logic [27:0] bank_width_sel_r;
   logic [27:0] bank_queue_sel_r;
   logic [27:0] bank_enabled_r;
   logic [7:0] payload_r [2][PAYLOAD_BYTES];
   logic [31:0] prdata_r;
   logic pready_r;
   logic pslverr_r;
   logic [27:0] match_en_r;
   logic words_wr_r;

   // Bank population mask: upper banks are reserved on the narrow variant.
   wire [27:0] bank_mask = WIDE_VARIANT ? 28'hfffffff : 28'h0003fff;
   wire [5:0] first_bank_mask = WIDE_VARIANT ? 6'h3f : 6'h00;

   // Address decode.
   wire hit_rx0_lo = PADDR == RX0_PAYLOAD_LOW_OFS;
   wire hit_rx0_hi = PADDR == RX0_PAYLOAD_HIGH_OFS;
   wire hit_rx1_lo = PADDR == RX1_PAYLOAD_LOW_OFS;
   wire hit_rx1_hi = PADDR == RX1_PAYLOAD_HIGH_OFS;
   wire hit_master = PADDR == FILTER_MASTER_OFS;
   wire hit_mode = PADDR == BANK_MODE_OFS;
   wire hit_scale = PADDR == BANK_SCALE_OFS;
   wire hit_queue = PADDR == BANK_QUEUE_OFS;
   wire hit_enable = PADDR == BANK_ENABLE_OFS;
   wire hit_any = hit_rx0_lo | hit_rx0_hi | hit_rx1_lo | hit_rx1_hi | hit_master |
      hit_mode | hit_scale | hit_queue | hit_enable;

   // A write commits in the access cycle, which is the one with pready high.
   wire wr_go = (state_r == CFRX_ACCESS) && PSEL && PENABLE && PWRITE;
   wire wr_master = wr_go && hit_master;
   wire wr_mode = wr_go && hit_mode && filter_setup_mode_r;
   wire wr_scale = wr_go && hit_scale && filter_setup_mode_r;
   wire wr_queue = wr_go && hit_queue && filter_setup_mode_r;
   wire wr_enable = wr_go && hit_enable;

   // Payload words assembled from stored bytes, byte 0 in the bottom lane.
   wire [31:0] rx0_lo = {payload_r[0][3], payload_r[0][2], payload_r[0][1], payload_r[0][0]};
   wire [31:0] rx0_hi = {payload_r[0][7], payload_r[0][6], payload_r[0][5], payload_r[0][4]};
   wire [31:0] rx1_lo = {payload_r[1][3], payload_r[1][2], payload_r[1][1], payload_r[1][0]};
   wire [31:0] rx1_hi = {payload_r[1][7], payload_r[1][6], payload_r[1][5], payload_r[1][4]};

   // Filter master read value: reserved bits always show their reset value.
   wire [31:0] master_rd = (FILTER_MASTER_RST & ~32'h00003f01) |
      {18'h00000, second_port_first_bank_r, 7'h00, filter_setup_mode_r};

   // Per-bank read words; the four reserved top bits are forced to zero.
   // Software may write ones there, but it never reads them back.
   wire [31:0] mode_rd = {4'h0, bank_list_or_mask_sel_r};
   wire [31:0] scale_rd = {4'h0, bank_width_sel_r};
   wire [31:0] queue_rd = {4'h0, bank_queue_sel_r};
   wire [31:0] enable_rd = {4'h0, bank_enabled_r};

   // Read data mux; an unmapped address reads as zero.
   wire [31:0] rd_mux =
      hit_rx0_lo ? rx0_lo :
      hit_rx0_hi ? rx0_hi :
      hit_rx1_lo ? rx1_lo :
      hit_rx1_hi ? rx1_hi :
      hit_master ? master_rd :
      hit_mode ? mode_rd :
      hit_scale ? scale_rd :
      hit_queue ? queue_rd :
      hit_enable ? enable_rd : 32'h00000000;

   // Acceptance may use a bank only if enabled and filters are running.
   wire [27:0] match_en_nxt = filter_setup_mode_r ? 28'h0000000 : bank_enabled_r;

   // A bank's filter words are writable when it is disabled or setup is on.
   wire bank_sel_ok = BANK_WORD_SEL < 5'(NUM_BANKS);
   wire bank_sel_off = bank_sel_ok && !bank_enabled_r[BANK_WORD_SEL];
   wire words_wr_nxt = filter_setup_mode_r | bank_sel_off;

   // Bus answer next values: the answer stands only in the access cycle.
   // They are taken from the next state so that ready rises with the access phase.
   wire enter_access = (state_nxt == CFRX_ACCESS);
   wire pready_nxt = enter_access;
   wire pslverr_nxt = enter_access && !hit_any;
   wire [31:0] prdata_nxt = (enter_access && !PWRITE) ? rd_mux : 32'h00000000;

   // Filter master next values; without a committed write the old value is kept.
   // The first-bank field is masked to zero on the narrow variant.
   wire filter_setup_mode_nxt = wr_master ? PWDATA[SETUP_MODE_BIT] : filter_setup_mode_r;
   wire [5:0] first_bank_wr = PWDATA[FIRST_BANK_LSB +: FIRST_BANK_W] & first_bank_mask;
   wire [5:0] second_port_first_bank_nxt = wr_master ? first_bank_wr : second_port_first_bank_r;

   // Per-bank next values; banks absent on the narrow variant stay at zero.
   // The write enables already carry the setup-mode lock where it applies.
   wire [27:0] bank_wr_data = PWDATA[27:0] & bank_mask;
   wire [27:0] bank_list_or_mask_sel_nxt = wr_mode ? bank_wr_data : bank_list_or_mask_sel_r;
   wire [27:0] bank_width_sel_nxt = wr_scale ? bank_wr_data : bank_width_sel_r;
   wire [27:0] bank_queue_sel_nxt = wr_queue ? bank_wr_data : bank_queue_sel_r;
   wire [27:0] bank_enabled_nxt = wr_enable ? bank_wr_data : bank_enabled_r;

   // Slave sequencing: setup, one access cycle with pready, then the done state and idle or the next access.
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         CFRX_IDLE: begin
            if (PSEL && !PENABLE) begin
               state_nxt = CFRX_ACCESS;
            end
         end
         CFRX_ACCESS: begin
            state_nxt = CFRX_DONE;
         end
         CFRX_DONE: begin
            state_nxt = (PSEL && !PENABLE) ? CFRX_ACCESS : CFRX_IDLE;
         end
         default: begin
            state_nxt = CFRX_IDLE;
         end
      endcase
   end

   // Bus state register.
   // Only the sequencer's state lives here; the answer flops follow below.
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         state_r <= CFRX_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Ready flop: high for exactly the access cycle of each transfer.
   // The slave never stretches a transfer, so no wait state is inserted.
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         pready_r <= 1'b0;
      end else begin
         pready_r <= pready_nxt;
      end
   end

   // Error flop: an unmapped address is flagged together with ready.
   // The write is then dropped and the read returns zero.
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         pslverr_r <= 1'b0;
      end else begin
         pslverr_r <= pslverr_nxt;
      end
   end

   // Read data flop: zero except during the access cycle of a read.
   // Clearing it elsewhere keeps a stale word from looking like an answer.
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         prdata_r <= 32'h00000000;
      end else begin
         prdata_r <= prdata_nxt;
      end
   end

   // Filter setup bit; it gates the mode, scale and queue registers.
   // It resets to one so that banks can be configured before filtering starts.
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         filter_setup_mode_r <= FILTER_MASTER_RST[SETUP_MODE_BIT];
      end else begin
         filter_setup_mode_r <= filter_setup_mode_nxt;
      end
   end

   // First bank of the second port; writes load zero on the narrow part.
   // The field is not range checked, so software must keep it within 1 to 27.
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         second_port_first_bank_r <= FILTER_MASTER_RST[FIRST_BANK_LSB +: FIRST_BANK_W];
      end else begin
         second_port_first_bank_r <= second_port_first_bank_nxt;
      end
   end

   // Bank mode bits, reset to identifier-mask mode for every bank.
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         bank_list_or_mask_sel_r <= BANK_BITS_RST;
      end else begin
         bank_list_or_mask_sel_r <= bank_list_or_mask_sel_nxt;
      end
   end

   // Bank scale bits, reset to the dual 16-bit arrangement.
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         bank_width_sel_r <= BANK_BITS_RST;
      end else begin
         bank_width_sel_r <= bank_width_sel_nxt;
      end
   end

   // Bank queue bits, reset so that every bank feeds queue 0.
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         bank_queue_sel_r <= BANK_BITS_RST;
      end else begin
         bank_queue_sel_r <= bank_queue_sel_nxt;
      end
   end

   // Bank enable bits, reset to all banks off.
   // They are writable at any time; the bank words and the match enable set depend on them.
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         bank_enabled_r <= BANK_BITS_RST;
      end else begin
         bank_enabled_r <= bank_enabled_nxt;
      end
   end

   // Registered enable set seen by the matching engine; it lags by one cycle.
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         match_en_r <= BANK_BITS_RST;
      end else begin
         match_en_r <= match_en_nxt;
      end
   end

   // Registered write permission for the selected bank's filter words.
   // After reset setup mode is on, so every bank starts out writable.
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         words_wr_r <= 1'b1;
      end else begin
         words_wr_r <= words_wr_nxt;
      end
   end

   // Payload storage: only the receive path loads it, the bus never does.
   // Each queue keeps the bytes of its most recently stored message, byte 0 lowest.
   for (genvar q = 0; q < 2; q++) begin : g_queue
      // A store strobe lands only in the queue that the receive path names.
      wire store_here = RX_STORE && (RX_STORE_QUEUE == 1'(q));
      for (genvar b = 0; b < PAYLOAD_BYTES; b++) begin : g_byte
         // Bytes beyond the message length keep whatever the receive path stored.
         wire [7:0] byte_nxt = store_here ? RX_STORE_PAYLOAD[b*BYTE_W +: BYTE_W] : payload_r[q][b];
         always_ff @(posedge CLK) begin
            if (SYS_RST) begin
               payload_r[q][b] <= 8'h00;
            end else begin
               payload_r[q][b] <= byte_nxt;
            end
         end
      end
   end

   assign PRDATA = prdata_r;
   assign PREADY = pready_r;
   assign PSLVERR = pslverr_r;
   assign FILTER_SETUP_MODE = filter_setup_mode_r;
   assign SECOND_PORT_FIRST_BANK = second_port_first_bank_r;
   assign BANK_LIST_OR_MASK_SEL = bank_list_or_mask_sel_r;
   assign BANK_WIDTH_SEL = bank_width_sel_r;
   assign BANK_QUEUE_SEL = bank_queue_sel_r;
   assign BANK_MATCH_ENABLED = match_en_r;
   assign BANK_WORDS_WRITABLE = words_wr_r;

endmodule

`default_nettype wire

/* testbench/cfrx_regs_checker.sv */
`timescale 1ns/1ps
`default_nettype none
// Watches the register slice from its ports only.
module cfrx_regs_checker
   import cfrx_pkg::*;
(
   input wire logic CLK,
   input wire logic SYS_RST,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [31:0] PRDATA,
   input wire logic PREADY,
   input wire logic FILTER_SETUP_MODE,
   input wire logic [5:0] SECOND_PORT_FIRST_BANK,
   input wire logic [27:0] BANK_LIST_OR_MASK_SEL,
   input wire logic [27:0] BANK_MATCH_ENABLED
);
   logic [31:0] wd_r;
   logic acc_wr;
   logic acc_rd;
   default clocking @(posedge CLK); endclocking
   default disable iff (SYS_RST);
   // Completed transfers, split by direction.
   assign acc_wr = PSEL && PENABLE && PREADY && PWRITE;
   assign acc_rd = PSEL && PENABLE && PREADY && !PWRITE;
   // Keeps the write data of the last edge for comparison after commit.
   always_ff @(posedge CLK) wd_r <= PWDATA;
   chk_answer_next: assert property (PSEL && !PENABLE |=> PREADY) else $error("no answer in access cycle");
   chk_setup_bit: assert property (acc_wr && PADDR == FILTER_MASTER_OFS
      |=> FILTER_SETUP_MODE == wd_r[0]) else $error("setup bit not taken");
   chk_first_bank: assert property (acc_wr && PADDR == FILTER_MASTER_OFS
      |=> SECOND_PORT_FIRST_BANK == wd_r[13:8]) else $error("first bank not taken");
   chk_mode_write: assert property (acc_wr && FILTER_SETUP_MODE && PADDR == BANK_MODE_OFS
      |=> BANK_LIST_OR_MASK_SEL == wd_r[27:0]) else $error("mode write lost");
   chk_mode_lock: assert property (acc_wr && !FILTER_SETUP_MODE && PADDR == BANK_MODE_OFS
      |=> $stable(BANK_LIST_OR_MASK_SEL)) else $error("mode changed while locked");
   chk_master_rsvd: assert property (acc_rd && PADDR == FILTER_MASTER_OFS |->
      PRDATA[31:14] == FILTER_MASTER_RST[31:14] && PRDATA[7:1] == FILTER_MASTER_RST[7:1]) else $error("reserved bits");
   chk_bank_top: assert property (acc_rd && PADDR inside {12'h204, 12'h20c, 12'h214, 12'h21c}
      |-> PRDATA[31:28] == 4'h0) else $error("bank top bits not zero");
   chk_match_gate: assert property (FILTER_SETUP_MODE |=> BANK_MATCH_ENABLED == 28'h0)
      else $error("match enabled in setup mode");
endmodule
bind cfrx_regs cfrx_regs_checker chk_u (.CLK(CLK), .SYS_RST(SYS_RST), .PSEL(PSEL), .PENABLE(PENABLE),
   .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
   .FILTER_SETUP_MODE(FILTER_SETUP_MODE), .SECOND_PORT_FIRST_BANK(SECOND_PORT_FIRST_BANK),
   .BANK_LIST_OR_MASK_SEL(BANK_LIST_OR_MASK_SEL), .BANK_MATCH_ENABLED(BANK_MATCH_ENABLED));
`default_nettype wire

/* testbench/cfrx_regs_test.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) compares++; if ((got) !== (ex)) begin n_mismatch++; $display("unexpected %s exp %h got %h", nm, ex, got); end
module cfrx_regs_test;
   import cfrx_pkg::*;
   typedef struct {logic w; logic [11:0] a; logic [31:0] d; logic [31:0] r; logic e;} cfrx_row_t;
   logic clk = 1'h0, sys_rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, rx_store = 1'h0, rx_q = 1'h0;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0;
   logic [63:0] rx_pl = 64'h0;
   logic [4:0] word_sel = 5'h0;
   logic [31:0] prdata;
   logic pready, pslverr, setup_mode, words_ok;
   logic [5:0] first_bank;
   logic [27:0] mode_sel, width_sel, queue_sel, match_en;
   int n_mismatch = 0, compares = 0, cycles = 0;
   logic [11:0] bank_ofs [4] = '{12'h204, 12'h20c, 12'h214, 12'h21c};
   // Ordinary transfers: direction, address, write data, read data and error expected.
   cfrx_row_t rows [$] = '{
      '{1,12'h200,32'hffffffff,0,0}, '{0,12'h200,0,32'h2a1c3f01,0}, '{1,12'h204,32'h5a5a5a5a,0,0},
      '{0,12'h204,0,32'h0a5a5a5a,0}, '{1,12'h20c,32'hffffffff,0,0}, '{0,12'h20c,0,32'h0fffffff,0},
      '{1,12'h214,32'h12345678,0,0}, '{0,12'h214,0,32'h02345678,0}, '{1,12'h21c,32'hf,0,0},
      '{1,12'h200,32'h1b00,0,0}, '{0,12'h200,0,32'h2a1c1b00,0}, '{1,12'h204,32'hffffffff,0,0},
      '{0,12'h204,0,32'h0a5a5a5a,0}, '{1,12'h21c,32'hf0000003,0,0}, '{0,12'h21c,0,32'h3,0},
      '{0,12'h220,0,0,1}, '{1,12'h208,32'h5,0,1}, '{0,12'h1b8,0,32'h44332211,0},
      '{0,12'h1bc,0,32'h88776655,0}, '{0,12'h1c8,0,32'h89abcdef,0}, '{0,12'h1cc,0,32'h01234567,0},
      '{1,12'h1b8,32'hdeadbeef,0,0}, '{0,12'h1b8,0,32'h44332211,0}};
   cfrx_regs dut_u (.CLK(clk), .SYS_RST(sys_rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .RX_STORE(rx_store),
      .RX_STORE_QUEUE(rx_q), .RX_STORE_PAYLOAD(rx_pl), .BANK_WORD_SEL(word_sel), .FILTER_SETUP_MODE(setup_mode),
      .SECOND_PORT_FIRST_BANK(first_bank), .BANK_LIST_OR_MASK_SEL(mode_sel), .BANK_WIDTH_SEL(width_sel),
      .BANK_QUEUE_SEL(queue_sel), .BANK_MATCH_ENABLED(match_en), .BANK_WORDS_WRITABLE(words_ok));
   // Clock at 10 MHz.
   always #50 clk = ~clk;
   // Prints the counts and the verdict, then stops.
   task automatic give_verdict();
      $display("mismatches %0d compares %0d", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // One APB transfer after an idle cycle; the request holds until pready is sampled high.
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] rd, output logic er);
      int n = 0;
      @(posedge clk);
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'h1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'h1 && n < 50);
      rd = prdata;
      er = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   // Cuts a hang short.
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         n_mismatch++;
         give_verdict();
      end
   end
   // Main sequence: table, then state outputs, setup re-entry and a mid-run reset.
   initial begin
      logic [31:0] rd;
      logic er;
      repeat (2) @(posedge clk);
      sys_rst <= 1'h0;
      @(posedge clk);
      rx_store <= 1'h1;
      rx_pl <= 64'h8877665544332211;
      @(posedge clk);
      rx_q <= 1'h1;
      rx_pl <= 64'h0123456789abcdef;
      @(posedge clk);
      rx_store <= 1'h0;
      foreach (rows[i]) begin
         apb(rows[i].w, rows[i].a, rows[i].d, rd, er);
         `CHK("prdata", rows[i].r, rd)
         `CHK("pslverr", rows[i].e, er)
      end
      repeat (2) @(posedge clk);
      `CHK("match_en", 28'h3, match_en)
      `CHK("words_ok", 1'h0, words_ok)
      `CHK("first_bank", 6'h1b, first_bank)
      `CHK("mode_sel", 28'ha5a5a5a, mode_sel)
      `CHK("width_sel", 28'hfffffff, width_sel)
      `CHK("queue_sel", 28'h2345678, queue_sel)
      word_sel <= 5'h5;
      repeat (2) @(posedge clk);
      `CHK("words_ok", 1'h1, words_ok)
      word_sel <= 5'h0;
      apb(1'h1, 12'h200, 32'h1, rd, er);
      repeat (2) @(posedge clk);
      `CHK("words_ok", 1'h1, words_ok)
      `CHK("match_en", 28'h0, match_en)
      sys_rst <= 1'h1;
      repeat (2) @(posedge clk);
      sys_rst <= 1'h0;
      apb(1'h0, 12'h200, 32'h0, rd, er);
      `CHK("master", FILTER_MASTER_RST, rd)
      foreach (bank_ofs[i]) begin
         apb(1'h0, bank_ofs[i], 32'h0, rd, er);
         `CHK("bank reg", 32'h0, rd)
      end
      give_verdict();
   end
endmodule
`default_nettype wire
